// file: rtl/mcsp_pkg.sv
// package for the modem control serial port: register map, fields, timing
// assumes a single 250 MHz clock domain and a plain strobe register port
package mcsp_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_TXDATA = 4'h1;
  localparam logic [3:0] ADDR_RXDATA = 4'h2;
  localparam logic [3:0] ADDR_STAT = 4'h3;
  localparam logic [3:0] ADDR_IRQ = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h5;
  localparam logic [3:0] ADDR_DIV = 4'h6;
  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  localparam int CTRL_RTS = 0;
  localparam int CTRL_DTR = 1;
  localparam int CTRL_SYNC = 2;
  localparam int CTRL_TWOSTOP = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ------------------------------------------------------------
  // status fields: modem levels and flags
  // ------------------------------------------------------------
  localparam int ST_DCD = 0;
  localparam int ST_DSR = 1;
  localparam int ST_CTS = 2;
  localparam int ST_RI = 3;
  localparam int ST_TXBUSY = 4;
  localparam int ST_RXFULL = 5;
  localparam int ST_DTRHOLD = 6;
  // interrupt events
  localparam int EV_MODEM = 0;
  localparam int EV_TXDONE = 1;
  localparam int EV_RXDONE = 2;
  localparam int EV_FRAME = 3;
  localparam int EV_OVERRUN = 4;
  localparam int EV_WIDTH = 5;
  // ------------------------------------------------------------
  // timing: asynchronous bit time in clock cycles, 16 samples per bit
  // ------------------------------------------------------------
  localparam int OVERSAMPLE = 16;
  localparam logic [15:0] DIV_RESET = 16'h00a3; // about 95k baud x16 at 250 MHz
  localparam int DATA_BITS = 8;
  typedef struct packed {
    logic dcd;
    logic dsr;
    logic cts;
    logic ri;
  } mcsp_modem_type;
endpackage

// file: rtl/mcsp_port.sv
// modem control serial port: async or sync framing with modem handshake
// assumes modem pins and element clocks arrive asynchronous to clk
//
// Operation
// [R1] transmit each character least significant bit first through the last data bit
// [R2] async characters carry one start bit and one or two stop bits
// [R3] the receiver expects the same order and framing the transmitter uses
// [R4] request-to-send is driven active before any transmission
// [R5] on half-duplex links the modem turns the line using request-to-send
// [R6] after raising request-to-send, send nothing until clear-to-send comes back
// [R7] start only while clear-to-send is active, and ignore it while rts is low
// [R8] data-set-ready is reported as local modem readiness only
// [R9] the receiver is idle and takes no data until carrier detect is active
// [R10] sync transmit data changes at the rising edge of the modem transmit clock
// [R11] the modem samples transmit data at the falling edge of its transmit clock
// [R12] the modem changes receive data at the rising edge of the receive clock
// [R13] sync receive data is sampled at the falling edge of the receive clock
// [R14] the port never drives a transmit clock toward the modem
// [R15] dtr drops to end a call and is not raised again until dsr has dropped
// [R16] modem levels are readable status and any change is flagged
`timescale 1ns/1ns
`default_nettype none
module mcsp_port #(
  parameter int DATA_W = mcsp_pkg::DATA_BITS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  output logic irq,
  // modem interface
  output logic txData,
  input wire logic rxData,
  output logic rtsOut,
  output logic dtrOut,
  input wire logic ctsIn,
  input wire logic dsrIn,
  input wire logic dcdIn,
  input wire logic riIn,
  input wire logic txClkIn,
  input wire logic rxClkIn
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  localparam int NSYNC = 7;
  // receive data idles high; resetting its stages low would fake a start bit
  localparam logic [NSYNC-1:0] PIN_IDLE = 7'h10;
  logic [NSYNC-1:0] pinRaw;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] pin_q;
  logic [NSYNC-1:0] pinDly_q;
  assign pinRaw = {rxClkIn, txClkIn, rxData, riIn, ctsIn, dsrIn, dcdIn};
  // two flops per pin, then one more stage for edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= PIN_IDLE;
      pin_q <= PIN_IDLE;
      pinDly_q <= PIN_IDLE;
    end else begin
      meta_q <= pinRaw;
      pin_q <= meta_q;
      pinDly_q <= pin_q;
    end
  end
  mcsp_pkg::mcsp_modem_type modem;
  assign modem = '{dcd: pin_q[0], dsr: pin_q[1], cts: pin_q[2], ri: pin_q[3]};
  logic rxLine;
  logic txClkRise;
  logic rxClkFall;
  assign rxLine = pin_q[4];
  assign txClkRise = pin_q[5] & ~pinDly_q[5];
  assign rxClkFall = ~pin_q[6] & pinDly_q[6];

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [15:0] div_q;
  logic [5:0] mask_q;
  logic [DATA_W-1:0] txHold_q;
  logic txPend_q;
  logic dtrHold_q;
  logic txStart;
  logic txDoneEv;
  logic syncMode;
  assign syncMode = ctrl_q[mcsp_pkg::CTRL_SYNC];
  // software control, tx pending flag cleared when the shifter takes the holding register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= mcsp_pkg::CTRL_RESET;
      div_q <= mcsp_pkg::DIV_RESET;
      mask_q <= '0;
      txHold_q <= '0;
      txPend_q <= 1'b0;
    end else begin
      if (regWr && regAddr == mcsp_pkg::ADDR_CTRL) begin
        ctrl_q <= regWdata[7:0];
      end
      if (regWr && regAddr == mcsp_pkg::ADDR_DIV) begin
        div_q <= regWdata;
      end
      if (regWr && regAddr == mcsp_pkg::ADDR_MASK) begin
        mask_q <= regWdata[5:0];
      end
      if (regWr && regAddr == mcsp_pkg::ADDR_TXDATA && !txPend_q) begin
        txHold_q <= regWdata[DATA_W-1:0];
        txPend_q <= 1'b1;
      end else if (txStart) begin
        txPend_q <= 1'b0;
      end
    end
  end

  // dtr follows software but stays low after a drop until dsr goes away
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dtrOut <= 1'b0;
      dtrHold_q <= 1'b0;
      rtsOut <= 1'b0;
    end else begin
      rtsOut <= ctrl_q[mcsp_pkg::CTRL_RTS]; // R4
      if (dtrOut && !ctrl_q[mcsp_pkg::CTRL_DTR]) begin
        dtrHold_q <= 1'b1; // R15
      end else if (!modem.dsr) begin
        dtrHold_q <= 1'b0; // R15
      end
      dtrOut <= ctrl_q[mcsp_pkg::CTRL_DTR] & ~(dtrHold_q & modem.dsr) & ~(dtrOut == 1'b0 &&
        dtrHold_q); // R15
    end
  end

  // ------------------------------------------------------------
  // baud tick: one cycle enable at 16x bit rate
  // ------------------------------------------------------------
  logic [15:0] divCnt_q;
  logic tick;
  assign tick = (divCnt_q == 16'h0000);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCnt_q <= mcsp_pkg::DIV_RESET;
    end else if (tick) begin
      divCnt_q <= div_q;
    end else begin
      divCnt_q <= divCnt_q - 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} mcsp_txst_type;
  mcsp_txst_type txSt_q;
  logic [DATA_W-1:0] txSh_q;
  logic [3:0] txBit_q;
  logic [3:0] txSub_q;
  logic txStep;
  logic clearToSend;
  // cts only counts while rts is asserted; a modem holding it alone is ignored
  assign clearToSend = modem.cts & rtsOut; // R7
  // sync mode steps on the modem clock rising edge, async on every 16th tick
  assign txStep = syncMode ? txClkRise : (tick && txSub_q == 4'hf); // R10 R14
  assign txStart = txStep && txSt_q == TX_IDLE && txPend_q && clearToSend; // R6 R7
  assign txDoneEv = txStep && txSt_q == TX_STOP && txBit_q == 4'h0;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txSt_q <= TX_IDLE;
      txSh_q <= '0;
      txBit_q <= '0;
      txSub_q <= '0;
      txData <= 1'b1;
    end else begin
      if (tick) begin
        txSub_q <= txSub_q + 4'h1;
      end
      if (txStep) begin
        case (txSt_q)
          TX_IDLE: begin
            txData <= 1'b1;
            if (txStart) begin
              txSh_q <= txHold_q;
              txBit_q <= 4'(DATA_W - 1);
              if (syncMode) begin
                txData <= txHold_q[0]; // R10
                txSh_q <= txHold_q >> 1;
                txSt_q <= TX_DATA;
              end else begin
                txData <= 1'b0; // R2
                txSt_q <= TX_START;
              end
            end
          end
          TX_START: begin
            txData <= txSh_q[0]; // R1
            txSh_q <= txSh_q >> 1;
            txSt_q <= TX_DATA;
          end
          TX_DATA: begin
            if (txBit_q == 4'h0) begin
              txData <= 1'b1; // R2
              txBit_q <= ctrl_q[mcsp_pkg::CTRL_TWOSTOP] ? 4'h1 : 4'h0;
              txSt_q <= syncMode ? TX_IDLE : TX_STOP;
            end else begin
              txData <= txSh_q[0]; // R1
              txSh_q <= txSh_q >> 1;
              txBit_q <= txBit_q - 4'h1;
            end
          end
          TX_STOP: begin
            txData <= 1'b1;
            if (txBit_q == 4'h0) begin
              txSt_q <= TX_IDLE;
            end else begin
              txBit_q <= txBit_q - 4'h1;
            end
          end
          default: txSt_q <= TX_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // receiver, held idle without carrier
  // ------------------------------------------------------------
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} mcsp_rxst_type;
  mcsp_rxst_type rxSt_q;
  logic [DATA_W-1:0] rxSh_q;
  logic [DATA_W-1:0] rxBuf_q;
  logic [3:0] rxBit_q;
  logic [3:0] rxSub_q;
  logic rxFull_q;
  logic rxDoneEv;
  logic frameEv;
  logic rxSample;
  // async samples at mid bit; sync on modem receive clock falling edge
  assign rxSample = syncMode ? rxClkFall : (tick && rxSub_q == 4'h7); // R13
  always_ff @(posedge clk) begin
    if (!rst_n || !modem.dcd) begin
      rxSt_q <= RX_IDLE; // R9
      rxSh_q <= '0;
      rxBit_q <= '0;
      rxSub_q <= '0;
      rxDoneEv <= 1'b0;
      frameEv <= 1'b0;
    end else begin
      rxDoneEv <= 1'b0;
      frameEv <= 1'b0;
      if (tick) begin
        rxSub_q <= rxSub_q + 4'h1;
      end
      case (rxSt_q)
        RX_IDLE: begin
          rxBit_q <= 4'(DATA_W - 1);
          if (syncMode) begin
            rxSt_q <= RX_DATA;
          end else if (!rxLine) begin
            rxSub_q <= '0; // align to falling start edge
            rxSt_q <= RX_START;
          end
        end
        RX_START: begin
          if (rxSample) begin
            rxSt_q <= rxLine ? RX_IDLE : RX_DATA; // glitch rejected, R3
          end
        end
        RX_DATA: begin
          if (rxSample) begin
            rxSh_q <= {rxLine, rxSh_q[DATA_W-1:1]}; // R3
            if (rxBit_q == 4'h0) begin
              rxBit_q <= 4'(DATA_W - 1);
              if (syncMode) begin
                rxDoneEv <= 1'b1;
              end else begin
                rxSt_q <= RX_STOP;
              end
            end else begin
              rxBit_q <= rxBit_q - 4'h1;
            end
          end
        end
        RX_STOP: begin
          if (rxSample) begin
            rxDoneEv <= 1'b1;
            frameEv <= ~rxLine; // R2
            rxSt_q <= RX_IDLE;
          end
        end
        default: rxSt_q <= RX_IDLE;
      endcase
    end
  end

  // receive buffer; a read of the data register empties it
  logic overEv;
  assign overEv = rxDoneEv & rxFull_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxBuf_q <= '0;
      rxFull_q <= 1'b0;
    end else if (rxDoneEv) begin
      rxBuf_q <= rxSh_q; // new character wins over a read
      rxFull_q <= 1'b1;
    end else if (regRd && regAddr == mcsp_pkg::ADDR_RXDATA) begin
      rxFull_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // interrupt status: set wins over write-one-to-clear
  // ------------------------------------------------------------
  logic [5:0] irqSt_q;
  logic [5:0] events;
  logic modemChange;
  assign modemChange = |(pin_q[3:0] ^ pinDly_q[3:0]); // R16
  assign events = {1'b0, overEv, frameEv, rxDoneEv, txDoneEv, modemChange};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqSt_q <= '0;
      irq <= 1'b0;
    end else begin
      if (regWr && regAddr == mcsp_pkg::ADDR_IRQ) begin
        irqSt_q <= (irqSt_q & ~regWdata[5:0]) | events;
      end else begin
        irqSt_q <= irqSt_q | events;
      end
      irq <= |(irqSt_q & mask_q);
    end
  end

  // ------------------------------------------------------------
  // read port, data valid the cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdata <= '0;
    end else if (regRd) begin
      case (regAddr)
        mcsp_pkg::ADDR_CTRL: regRdata <= {8'h00, ctrl_q};
        mcsp_pkg::ADDR_RXDATA: regRdata <= 16'(rxBuf_q);
        // dsr bit is local modem readiness, nothing about the far end
        mcsp_pkg::ADDR_STAT: regRdata <= {9'h000, dtrHold_q, rxFull_q,
          txSt_q != TX_IDLE || txPend_q, modem.ri, modem.cts, modem.dsr, modem.dcd}; // R8 R16
        mcsp_pkg::ADDR_IRQ: regRdata <= {10'h000, irqSt_q};
        mcsp_pkg::ADDR_MASK: regRdata <= {10'h000, mask_q};
        mcsp_pkg::ADDR_DIV: regRdata <= div_q;
        default: regRdata <= 16'h0000;
      endcase
    end else begin
      regRdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// file: sim/mcsp_modem_model.sv
// modem model: handshake, element clocks, serial data both ways
// assumes the bench calls its tasks; clocks stand still between frames
`timescale 1ns/1ns
`default_nettype none
module mcsp_modem_model (
  // from the port and the bench
  input wire logic txData,
  input wire logic rtsOut,
  input wire logic ctsHold,
  input wire logic [15:0] ctsLag,
  // to the port
  output logic ctsIn,
  output logic rxData,
  output logic txClkIn,
  output logic rxClkIn
);
  logic ctsLate = 1'b0;
  initial begin
    rxData = 1'b1;
    txClkIn = 1'b0;
    rxClkIn = 1'b0;
  end
  // cts answers rts after a lag; hold pins it on like a full-duplex set
  always @(rtsOut) ctsLate <= #(ctsLag) rtsOut;
  assign ctsIn = ctsLate | ctsHold;
  // async char toward the port, bit time 128 ns
  task automatic send_async(input logic [7:0] b, input logic stopLvl);
    logic [9:0] f;
    f = {stopLvl, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxData = f[i];
      #128;
    end
    rxData = 1'b1;
  endtask
  // sync char: data moves at the rising edge of our clock
  task automatic send_sync(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rxClkIn = 1'b1;
      rxData = b[i];
      #40;
      rxClkIn = 1'b0;
      #40;
    end
    rxData = ~b[7];
  endtask
  // sync capture at the falling edge of our transmit clock
  task automatic take_sync(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      txClkIn = 1'b1;
      #40;
      txClkIn = 1'b0;
      b[i] = txData;
      #40;
    end
  endtask
  // async capture, mid-bit sampling
  task automatic take_async(output logic [7:0] b, output logic ok);
    @(negedge txData);
    #64;
    ok = !txData;
    for (int i = 0; i < 8; i++) begin
      #128;
      b[i] = txData;
    end
    #128;
    ok = ok & txData;
  endtask
endmodule
`default_nettype wire

// file: sim/mcsp_port_assertions.sv
// checker for the serial port, watching only the port pins
// assumes one clock domain; bound onto every mcsp_port below
`timescale 1ns/1ns
`default_nettype none
module mcsp_port_checker (
  // clock and register port
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic irq,
  // modem pins
  input wire logic txData,
  input wire logic rtsOut,
  input wire logic dtrOut,
  input wire logic ctsIn,
  input wire logic dsrIn
);
  // ----------------------------------------
  // helper and properties
  // ----------------------------------------
  logic dsrLow_q;
  // dsr must be seen low between a dtr drop and the next rise
  always_ff @(posedge clk) begin
    if (!rst_n || !dsrIn) begin
      dsrLow_q <= 1'b1;
    end else if ($fell(dtrOut)) begin
      dsrLow_q <= 1'b0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_ctrlWr;
    regWr && regAddr == mcsp_pkg::ADDR_CTRL;
  endsequence
  sequence s_quiet;
    !(regWr && regAddr == mcsp_pkg::ADDR_CTRL);
  endsequence
  property p_rtsFollow;
    s_ctrlWr ##1 s_quiet |=> rtsOut == $past(regWdata[mcsp_pkg::CTRL_RTS], 2);
  endproperty
  a_rtsFollow: assert property (p_rtsFollow) else $error("rts off control");
  property p_startGate;
    $fell(txData) |-> rtsOut;
  endproperty
  a_startGate: assert property (p_startGate) else $error("start without rts");
  property p_ctsWait;
    (rtsOut && !ctsIn) [*6] |-> txData;
  endproperty
  a_ctsWait: assert property (p_ctsWait) else $error("sent before cts");
  property p_rtsIdle;
    !rtsOut [*6] |-> txData;
  endproperty
  a_rtsIdle: assert property (p_rtsIdle) else $error("sent with rts low");
  property p_startLen;
    $fell(txData) |-> !txData [*8];
  endproperty
  a_startLen: assert property (p_startLen) else $error("short low bit");
  property p_dtrDrop;
    regWr && regAddr == mcsp_pkg::ADDR_CTRL && !regWdata[mcsp_pkg::CTRL_DTR]
      |-> ##[1:3] !dtrOut;
  endproperty
  a_dtrDrop: assert property (p_dtrDrop) else $error("dtr not dropped");
  property p_dtrHold;
    $rose(dtrOut) |-> dsrLow_q;
  endproperty
  a_dtrHold: assert property (p_dtrHold) else $error("dtr raised early");
  property p_irqMask;
    regWr && regAddr == mcsp_pkg::ADDR_MASK && regWdata == 16'h0000 |-> ##[1:3] !irq;
  endproperty
  a_irqMask: assert property (p_irqMask) else $error("masked irq high");
endmodule
bind mcsp_port mcsp_port_checker chk (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .irq(irq), .txData(txData), .rtsOut(rtsOut),
  .dtrOut(dtrOut), .ctsIn(ctsIn), .dsrIn(dsrIn));
`default_nettype wire

// file: sim/modem_control_serial_port_tb_top.sv
// self-checking bench for the serial port with a modem model
// assumes the checker binds itself; DIV is set to 1 for 128 ns bits
`timescale 1ns/1ns
`default_nettype none
module modem_control_serial_port_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic dsrIn = 1'b0;
  logic dcdIn = 1'b0;
  logic riIn = 1'b0;
  logic ctsHold = 1'b0;
  logic [15:0] ctsLag = 16'h0028;
  logic [15:0] regRdata;
  logic irq, txData, rxData, rtsOut, dtrOut, ctsIn, txClkIn, rxClkIn;
  int errCount = 0;
  int totalChecks = 0;
  int cycles = 0;
  logic [7:0] seed = 8'h28;
  // ----------------------------------------
  // clock, design, modem
  // ----------------------------------------
  always #2 clk = ~clk;
  mcsp_port dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq), .txData(txData),
    .rxData(rxData), .rtsOut(rtsOut), .dtrOut(dtrOut), .ctsIn(ctsIn), .dsrIn(dsrIn),
    .dcdIn(dcdIn), .riIn(riIn), .txClkIn(txClkIn), .rxClkIn(rxClkIn));
  mcsp_modem_model modem (.txData(txData), .rtsOut(rtsOut), .ctsHold(ctsHold),
    .ctsLag(ctsLag), .ctsIn(ctsIn), .rxData(rxData), .txClkIn(txClkIn), .rxClkIn(rxClkIn));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] nextRand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // status nibble expected from modem levels
  function automatic logic [3:0] expStat(input logic dcd, dsr, cts, ri);
    logic [3:0] e;
    e[mcsp_pkg::ST_DCD] = dcd;
    e[mcsp_pkg::ST_DSR] = dsr;
    e[mcsp_pkg::ST_CTS] = cts;
    e[mcsp_pkg::ST_RI] = ri;
    return e;
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    v = regRdata;
  endtask
  task automatic completeRun;
    if (errCount == 0 && totalChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // hang guard, far above the ~8k cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errCount++;
      completeRun();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] got;
    logic ok;
    logic [15:0] d;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("idle pins", {txData, rtsOut, dtrOut, irq}, 16'h0008);
    rd(mcsp_pkg::ADDR_DIV, d);
    check("div reset", d, mcsp_pkg::DIV_RESET);
    rd(4'hf, d);
    check("unmapped", d, 16'h0000);
    wr(mcsp_pkg::ADDR_DIV, 16'h0001);
    wr(mcsp_pkg::ADDR_MASK, 16'h001f);
    ctsLag <= 16'd2000;
    wr(mcsp_pkg::ADDR_CTRL, 16'h0002);
    // async transmit: corner bytes then random ones, each behind a fresh slow cts
    for (int i = 0; i < 4; i++) begin
      seed = nextRand(seed);
      if (i < 2) seed = {8{i[0]}};
      fork
        modem.take_async(got, ok);
        begin
          wr(mcsp_pkg::ADDR_CTRL, 16'h0003);
          wr(mcsp_pkg::ADDR_TXDATA, {8'h00, seed});
          check("rts up", rtsOut, 1'b1);
          repeat (100) @(posedge clk);
          check("idle until cts", txData, 1'b1);
        end
      join
      check("tx char", {7'h00, ok, got}, {8'h01, seed});
      // drop rts and let the slow cts fall before the next character
      wr(mcsp_pkg::ADDR_CTRL, 16'h0002);
      repeat (520) @(posedge clk);
    end
    // cts pinned on while rts is low must not start a character
    ctsLag <= 16'h0028;
    wr(mcsp_pkg::ADDR_CTRL, 16'h0002);
    ctsHold <= 1'b1;
    wr(mcsp_pkg::ADDR_TXDATA, 16'h005a);
    repeat (200) @(posedge clk);
    check("cts ignored", txData, 1'b1);
    fork
      modem.take_async(got, ok);
      wr(mcsp_pkg::ADDR_CTRL, 16'h0003);
    join
    check("late char", {7'h00, ok, got}, 16'h015a);
    ctsHold <= 1'b0;
    repeat (20) @(posedge clk);
    // receiver held off without carrier, then carrier flags an event
    modem.send_async(8'h3c, 1'b1);
    wr(mcsp_pkg::ADDR_IRQ, 16'h001f);
    rd(mcsp_pkg::ADDR_STAT, d);
    check("rx idle", d[mcsp_pkg::ST_RXFULL], 1'b0);
    dcdIn <= 1'b1;
    repeat (8) @(posedge clk);
    rd(mcsp_pkg::ADDR_IRQ, d);
    check("modem event", d, 16'h0001 << mcsp_pkg::EV_MODEM);
    check("irq up", irq, 1'b1);
    wr(mcsp_pkg::ADDR_MASK, 16'h0000);
    repeat (3) @(posedge clk);
    check("irq masked", irq, 1'b0);
    wr(mcsp_pkg::ADDR_MASK, 16'h001f);
    wr(mcsp_pkg::ADDR_IRQ, 16'h0001 << mcsp_pkg::EV_MODEM);
    repeat (3) @(posedge clk);
    check("irq cleared", irq, 1'b0);
    for (int i = 0; i < 2; i++) begin
      seed = nextRand(seed);
      modem.send_async(seed, 1'b1);
      repeat (8) @(posedge clk);
      rd(mcsp_pkg::ADDR_RXDATA, d);
      check("rx char", d, {8'h00, seed});
    end
    modem.send_async(8'ha5, 1'b0);
    repeat (8) @(posedge clk);
    rd(mcsp_pkg::ADDR_IRQ, d);
    check("framing", d[mcsp_pkg::EV_FRAME], 1'b1);
    check("rx event", d[mcsp_pkg::EV_RXDONE], 1'b1);
    check("no overrun", d[mcsp_pkg::EV_OVERRUN], 1'b0);
    // modem levels read back as status
    wr(mcsp_pkg::ADDR_CTRL, 16'h0002);
    for (int i = 0; i < 4; i++) begin
      seed = nextRand(seed);
      {dcdIn, dsrIn, ctsHold, riIn} <= seed[3:0];
      repeat (20) @(posedge clk);
      rd(mcsp_pkg::ADDR_STAT, d);
      check("levels", d[3:0], expStat(seed[3], seed[2], seed[1], seed[0]));
    end
    // dtr held off after a drop until dsr goes low
    dsrIn <= 1'b1;
    wr(mcsp_pkg::ADDR_CTRL, 16'h0000);
    wr(mcsp_pkg::ADDR_CTRL, 16'h0002);
    repeat (8) @(posedge clk);
    check("dtr held", dtrOut, 1'b0);
    dsrIn <= 1'b0;
    repeat (8) @(posedge clk);
    check("dtr back", dtrOut, 1'b1);
    // synchronous mode on the modem element clocks
    ctsHold <= 1'b1;
    dcdIn <= 1'b0;
    wr(mcsp_pkg::ADDR_CTRL, 16'h0007);
    seed = nextRand(seed);
    wr(mcsp_pkg::ADDR_TXDATA, {8'h00, seed});
    repeat (8) @(posedge clk);
    modem.take_sync(got);
    check("sync tx", got, seed);
    dcdIn <= 1'b1;
    repeat (8) @(posedge clk);
    modem.send_sync(8'hc6);
    repeat (8) @(posedge clk);
    rd(mcsp_pkg::ADDR_RXDATA, d);
    check("sync rx", d, 16'h00c6);
    completeRun();
  end
endmodule
`default_nettype wire
